// ---- inc/isfl_pkg.sv ----
// Summary of operation
// - ext line flag sets on the edge type its edge field selects
// - ext request vectors only with global and line enables set
// - edge field: off, rising, falling or both edges
// - pin is ext input only if enabled, share-selected and direction input
// - pull-up selection stays in effect in ext input use
// - no vector call while the return stack is full
// - servicing ext line clears its flag and global enable
// - comparator flag sets on every change of its output
// - servicing comparator clears its flag and global enable
// - conversion end sets done flag; vectors with global and own enable
// - servicing conversion done clears its flag and global enable
// - group flag sets when any included source flag becomes set
// - group service clears group flag and global enable; sources stay
// - each timer has p and a match flags with own enables
// - timer request needs global, timer and group enables
// - low supply sets low-voltage flag feeding its group
// - eeprom cycle end sets nvm done flag feeding its group
// - global enable low blocks vectors, flags still recorded
// - each source has a fixed vector address in priority order
// - any set request flag raises wake
package isfl_pkg;
  localparam int ADDR_W = 8;
  localparam int N_VEC  = 10;
  localparam int N_SRC  = 7;
  localparam int N_EXT  = 4;

  localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] EDGE_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] SREN_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] FLAG_OFS = 8'h0c;
  localparam logic [ADDR_W-1:0] SRFL_OFS = 8'h10;
  localparam logic [ADDR_W-1:0] STAT_OFS = 8'h14;

  localparam logic [N_VEC:0]  CTRL_RST = 11'h000;
  localparam logic [15:0]     EDGE_RST = 16'h0000;
  localparam logic [N_SRC-1:0] SREN_RST = 7'h00;
  localparam logic [N_VEC-1:0] FLAG_RST = 10'h000;
  localparam logic [N_SRC-1:0] SRFL_RST = 7'h00;

  // vector slots, highest priority first
  localparam int V_EXT0 = 0;
  localparam int V_EXT1 = 1;
  localparam int V_CMPA = 2;
  localparam int V_CMPB = 3;
  localparam int V_MF0  = 4;
  localparam int V_MF1  = 5;
  localparam int V_CONV = 6;
  localparam int V_MF2  = 7;
  localparam int V_EXT2 = 8;
  localparam int V_EXT3 = 9;
  localparam logic [N_VEC-1:0][7:0] VEC_ADDR = {
    8'h34, 8'h30, 8'h20, 8'h1c, 8'h18, 8'h14, 8'h10, 8'h0c, 8'h08, 8'h04};

  // source flag bits
  localparam int S_STP = 0;
  localparam int S_STA = 1;
  localparam int S_PTP = 2;
  localparam int S_PTA = 3;
  localparam int S_LV  = 4;
  localparam int S_NVM = 5;
  localparam int S_SIF = 6;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    ISFL_EDGE_OFF  = 2'b00,
    ISFL_EDGE_RISE = 2'b01,
    ISFL_EDGE_FALL = 2'b10,
    ISFL_EDGE_BOTH = 2'b11
  } isfl_edge_e;

  typedef struct packed {
    logic              awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic              wvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [ADDR_W-1:0] araddr;
    logic              rready;
  } isfl_axi_req_s;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } isfl_axi_rsp_s;
endpackage : isfl_pkg

// ---- rtl/isfl_core.sv ----
// Added by the designer: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
module isfl_core (
  input  wire logic                   ref_clk,
  input  wire logic                   reset_n,
  input  wire isfl_pkg::isfl_axi_req_s axi_req,
  output isfl_pkg::isfl_axi_rsp_s     axi_rsp,
  input  wire logic [3:0]             ext_irq_pin,
  input  wire logic [3:0]             port_is_input,
  output logic [3:0]                  pull_up_on,
  input  wire logic [1:0]             cmp_out,
  input  wire logic                   conv_end,
  input  wire logic                   std_timer_p_hit,
  input  wire logic                   std_timer_a_hit,
  input  wire logic                   per_timer_p_hit,
  input  wire logic                   per_timer_a_hit,
  input  wire logic                   low_volt_detected,
  input  wire logic                   nvm_cycle_end,
  input  wire logic                   sif_request,
  input  wire logic                   stack_full,
  input  wire logic                   vec_ack,
  input  wire logic                   reti_done,
  output logic                        vec_req,
  output logic [7:0]                  vec_addr,
  output logic                        wake_req
);

  localparam int NV = isfl_pkg::N_VEC;
  localparam int NS = isfl_pkg::N_SRC;
  localparam int ADDR_W_L = isfl_pkg::ADDR_W;

  function automatic logic [3:0] first_set(input logic [NV-1:0] v);
    logic [3:0] r;
    r = 4'hf;
    for (int i = NV - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction : first_set

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[b*8 +: 8] = n[b*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // control and flag registers
  logic             gie_reg;
  logic [NV-1:0]    en_reg;
  logic [15:0]      edge_reg;
  logic [NS-1:0]    sren_reg;
  logic [NV-1:0]    flag_reg;
  logic [NS-1:0]    srfl_reg;
  logic             gie_next;
  logic [NV-1:0]    en_next;
  logic [15:0]      edge_next;
  logic [NS-1:0]    sren_next;
  logic [NV-1:0]    flag_next;
  logic [NS-1:0]    srfl_next;

  // synchronisers and edge history
  logic [3:0] pin_s1_reg;
  logic [3:0] pin_s2_reg;
  logic [3:0] pin_old_reg;
  logic [1:0] cmp_s1_reg;
  logic [1:0] cmp_s2_reg;
  logic [1:0] cmp_old_reg;

  // vector output state
  logic       vreq_reg;
  logic [7:0] vaddr_reg;
  logic [3:0] vidx_reg;

  // bus state
  logic              aw_hold_reg;
  logic [ADDR_W_L-1:0] aw_addr_reg;
  logic              w_hold_reg;
  logic [31:0]       w_data_reg;
  logic [3:0]        w_strb_reg;
  logic              bvalid_reg;
  logic [1:0]        bresp_reg;
  logic              rvalid_reg;
  logic [31:0]       rdata_reg;
  logic [1:0]        rresp_reg;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_s1_reg  <= 4'h0;
      pin_s2_reg  <= 4'h0;
      pin_old_reg <= 4'h0;
      cmp_s1_reg  <= 2'h0;
      cmp_s2_reg  <= 2'h0;
      cmp_old_reg <= 2'h0;
    end else begin
      pin_s1_reg  <= ext_irq_pin;
      pin_s2_reg  <= pin_s1_reg;
      pin_old_reg <= pin_s2_reg;
      cmp_s1_reg  <= cmp_out;
      cmp_s2_reg  <= cmp_s1_reg;
      cmp_old_reg <= cmp_s2_reg;
    end
  end

  // external edge qualification
  wire [3:0] pin_rise  = pin_s2_reg & ~pin_old_reg;
  wire [3:0] pin_fall  = ~pin_s2_reg & pin_old_reg;
  wire [3:0] share_sel = edge_reg[11:8];
  wire [3:0] ext_en    = {en_reg[isfl_pkg::V_EXT3], en_reg[isfl_pkg::V_EXT2],
                          en_reg[isfl_pkg::V_EXT1], en_reg[isfl_pkg::V_EXT0]};
  wire [3:0] pin_live  = ext_en & share_sel & port_is_input;
  logic [3:0] ext_hit;

  always_comb begin
    ext_hit = 4'h0;
    for (int i = 0; i < 4; i++) begin
      case (isfl_pkg::isfl_edge_e'(edge_reg[i*2 +: 2]))
        isfl_pkg::ISFL_EDGE_RISE: ext_hit[i] = pin_rise[i];
        isfl_pkg::ISFL_EDGE_FALL: ext_hit[i] = pin_fall[i];
        isfl_pkg::ISFL_EDGE_BOTH: ext_hit[i] = pin_rise[i] | pin_fall[i];
        default:                  ext_hit[i] = 1'b0;
      endcase
    end
  end

  wire [3:0] ext_set = ext_hit & pin_live;
  wire [1:0] cmp_set = cmp_s2_reg ^ cmp_old_reg;

  // source flags and group feed
  wire [NS-1:0] src_in = {sif_request, nvm_cycle_end, low_volt_detected,
                          per_timer_a_hit, per_timer_p_hit, std_timer_a_hit, std_timer_p_hit};
  wire [NS-1:0] src_rise = src_in & ~srfl_reg & sren_reg;
  wire grp0_set = |src_rise[isfl_pkg::S_PTA:isfl_pkg::S_STP];
  wire grp1_set = src_rise[isfl_pkg::S_LV] | src_rise[isfl_pkg::S_NVM];
  wire grp2_set = src_rise[isfl_pkg::S_SIF];

  logic [NV-1:0] hw_set;
  always_comb begin
    hw_set = '0;
    hw_set[isfl_pkg::V_EXT0] = ext_set[0];
    hw_set[isfl_pkg::V_EXT1] = ext_set[1];
    hw_set[isfl_pkg::V_EXT2] = ext_set[2];
    hw_set[isfl_pkg::V_EXT3] = ext_set[3];
    hw_set[isfl_pkg::V_CMPA] = cmp_set[0];
    hw_set[isfl_pkg::V_CMPB] = cmp_set[1];
    hw_set[isfl_pkg::V_CONV] = conv_end;
    hw_set[isfl_pkg::V_MF0]  = grp0_set;
    hw_set[isfl_pkg::V_MF1]  = grp1_set;
    hw_set[isfl_pkg::V_MF2]  = grp2_set;
  end

  // vector selection
  wire [NV-1:0] armed    = flag_reg & en_reg;
  wire [3:0]    pick     = first_set(armed);
  wire          can_call = gie_reg & ~stack_full & (|armed);
  wire          ack_take = vreq_reg & vec_ack;
  wire [NV-1:0] svc_clr  = ack_take ? (NV'(1) << vidx_reg) : '0;

  // bus decode
  wire          wr_go   = aw_hold_reg & w_hold_reg & ~bvalid_reg;
  wire          rd_take = axi_req.arvalid & ~rvalid_reg;
  wire [ADDR_W_L-1:0] wa = {aw_addr_reg[ADDR_W_L-1:2], 2'b00};
  wire [ADDR_W_L-1:0] ra = {axi_req.araddr[ADDR_W_L-1:2], 2'b00};
  wire wr_ctrl = wr_go & (wa == isfl_pkg::CTRL_OFS);
  wire wr_edge = wr_go & (wa == isfl_pkg::EDGE_OFS);
  wire wr_sren = wr_go & (wa == isfl_pkg::SREN_OFS);
  wire wr_flag = wr_go & (wa == isfl_pkg::FLAG_OFS);
  wire wr_srfl = wr_go & (wa == isfl_pkg::SRFL_OFS);
  wire wr_map  = wr_ctrl | wr_edge | wr_sren | wr_flag | wr_srfl | (wa == isfl_pkg::STAT_OFS);
  wire [31:0] wmask = merge(32'h0, 32'hffffffff, w_strb_reg);
  wire [31:0] w1c   = w_data_reg & wmask;

  wire [31:0] ctrl_new = merge({21'h0, en_reg, gie_reg}, w_data_reg, w_strb_reg);
  wire [31:0] edge_new = merge({16'h0, edge_reg}, w_data_reg, w_strb_reg);
  wire [31:0] sren_new = merge({25'h0, sren_reg}, w_data_reg, w_strb_reg);

  logic [31:0] rd_val;
  logic        rd_ok;
  always_comb begin
    rd_ok = 1'b1;
    if (ra == isfl_pkg::CTRL_OFS) begin
      rd_val = {21'h0, en_reg, gie_reg};
    end else if (ra == isfl_pkg::EDGE_OFS) begin
      rd_val = {16'h0, edge_reg};
    end else if (ra == isfl_pkg::SREN_OFS) begin
      rd_val = {25'h0, sren_reg};
    end else if (ra == isfl_pkg::FLAG_OFS) begin
      rd_val = {22'h0, flag_reg};
    end else if (ra == isfl_pkg::SRFL_OFS) begin
      rd_val = {25'h0, srfl_reg};
    end else if (ra == isfl_pkg::STAT_OFS) begin
      rd_val = {23'h0, vreq_reg, vaddr_reg};
    end else begin
      rd_val = 32'h0;
      rd_ok  = 1'b0;
    end
  end

  // next state of control and flags
  always_comb begin
    gie_next  = gie_reg;
    en_next   = en_reg;
    edge_next = edge_reg;
    sren_next = sren_reg;
    if (wr_ctrl) begin
      gie_next = ctrl_new[0];
      en_next  = ctrl_new[NV:1];
    end
    if (reti_done) begin
      gie_next = 1'b1;
    end
    if (ack_take) begin
      gie_next = 1'b0;
    end
    if (wr_edge) begin
      edge_next = edge_new[15:0];
    end
    if (wr_sren) begin
      sren_next = sren_new[NS-1:0];
    end
    flag_next = (flag_reg & ~svc_clr & ~(wr_flag ? w1c[NV-1:0] : '0)) | hw_set;
    srfl_next = (srfl_reg & ~(wr_srfl ? w1c[NS-1:0] : '0)) | (src_in & sren_reg);
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      {en_reg, gie_reg} <= isfl_pkg::CTRL_RST;
      edge_reg          <= isfl_pkg::EDGE_RST;
      sren_reg          <= isfl_pkg::SREN_RST;
      flag_reg          <= isfl_pkg::FLAG_RST;
      srfl_reg          <= isfl_pkg::SRFL_RST;
    end else begin
      gie_reg  <= gie_next;
      en_reg   <= en_next;
      edge_reg <= edge_next;
      sren_reg <= sren_next;
      flag_reg <= flag_next;
      srfl_reg <= srfl_next;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      vreq_reg  <= 1'b0;
      vaddr_reg <= 8'h00;
      vidx_reg  <= 4'h0;
    end else begin
      vreq_reg  <= can_call & ~ack_take;
      vaddr_reg <= (can_call & ~ack_take) ? isfl_pkg::VEC_ADDR[pick] : 8'h00;
      vidx_reg  <= pick;
    end
  end

  // write channel
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      aw_hold_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_hold_reg  <= 1'b0;
      w_data_reg  <= 32'h0;
      w_strb_reg  <= 4'h0;
    end else begin
      if (axi_req.awvalid & ~aw_hold_reg) begin
        aw_hold_reg <= 1'b1;
        aw_addr_reg <= axi_req.awaddr;
      end else if (wr_go) begin
        aw_hold_reg <= 1'b0;
      end
      if (axi_req.wvalid & ~w_hold_reg) begin
        w_hold_reg <= 1'b1;
        w_data_reg <= axi_req.wdata;
        w_strb_reg <= axi_req.wstrb;
      end else if (wr_go) begin
        w_hold_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= isfl_pkg::RESP_OKAY;
    end else if (wr_go) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= wr_map ? isfl_pkg::RESP_OKAY : isfl_pkg::RESP_SLVERR;
    end else if (axi_req.bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // read channel
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0;
      rresp_reg  <= isfl_pkg::RESP_OKAY;
    end else if (rd_take) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rd_val;
      rresp_reg  <= rd_ok ? isfl_pkg::RESP_OKAY : isfl_pkg::RESP_SLVERR;
    end else if (axi_req.rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign axi_rsp.awready = ~aw_hold_reg;
  assign axi_rsp.wready  = ~w_hold_reg;
  assign axi_rsp.bvalid  = bvalid_reg;
  assign axi_rsp.bresp   = bresp_reg;
  assign axi_rsp.arready = ~rvalid_reg;
  assign axi_rsp.rvalid  = rvalid_reg;
  assign axi_rsp.rdata   = rdata_reg;
  assign axi_rsp.rresp   = rresp_reg;

  assign pull_up_on = edge_reg[15:12];
  assign vec_req    = vreq_reg;
  assign vec_addr   = vaddr_reg;
  assign wake_req   = (|flag_reg) | (|srfl_reg);

endmodule : isfl_core

// ---- bench/isfl_core_props.sv ----
`timescale 1ns/1ps
module isfl_core_props (
  input wire logic                    ref_clk,
  input wire logic                    reset_n,
  input wire isfl_pkg::isfl_axi_req_s axi_req,
  input wire isfl_pkg::isfl_axi_rsp_s axi_rsp,
  input wire logic [3:0]              pull_up_on,
  input wire logic [1:0]              cmp_out,
  input wire logic                    conv_end,
  input wire logic                    stack_full,
  input wire logic                    vec_ack,
  input wire logic                    vec_req,
  input wire logic [7:0]              vec_addr,
  input wire logic                    wake_req
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  property p_stack_hold; stack_full && !vec_req |=> !vec_req; endproperty
  a_stack_hold: assert property (p_stack_hold) else $error("call while stack full");
  property p_ack_clear; vec_req && vec_ack |=> !vec_req [*2]; endproperty
  a_ack_clear: assert property (p_ack_clear) else $error("call after ack");
  property p_vec_map;
    vec_req |-> vec_addr inside {8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h30, 8'h34};
  endproperty
  a_vec_map: assert property (p_vec_map) else $error("bad vector address");
  property p_idle_addr; !vec_req |-> vec_addr == 8'h00; endproperty
  a_idle_addr: assert property (p_idle_addr) else $error("address without call");
  property p_vec_hold; vec_req && !vec_ack |=> vec_req; endproperty
  a_vec_hold: assert property (p_vec_hold) else $error("call dropped before ack");
  property p_conv_wake; conv_end |=> wake_req; endproperty
  a_conv_wake: assert property (p_conv_wake) else $error("conversion end not flagged");
  property p_cmp_wake; $changed(cmp_out) |-> ##[1:4] wake_req; endproperty
  a_cmp_wake: assert property (p_cmp_wake) else $error("comparator change not flagged");
  property p_wake_fall; $fell(wake_req) |-> $past(vec_ack || axi_req.wvalid || !axi_rsp.wready); endproperty
  a_wake_fall: assert property (p_wake_fall) else $error("flag lost without clear");
  property p_pull_keep; $changed(pull_up_on) |-> $past(axi_req.awvalid || !axi_rsp.awready); endproperty
  a_pull_keep: assert property (p_pull_keep) else $error("pull-up changed without write");
endmodule : isfl_core_props

bind isfl_core isfl_core_props u_props (.ref_clk, .reset_n, .axi_req, .axi_rsp, .pull_up_on, .cmp_out,
  .conv_end, .stack_full, .vec_ack, .vec_req, .vec_addr, .wake_req);

// ---- bench/isfl_core_model.sv ----
`timescale 1ns/1ps
module isfl_core_model (
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  input  wire logic       vec_req,
  input  wire logic [3:0] ack_wait,
  input  wire logic [3:0] svc_len,
  output logic            vec_ack,
  output logic            reti_done
);
  logic [3:0] wait_cnt;
  logic [3:0] svc_cnt;
  logic       in_svc;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      wait_cnt  <= 4'h0;
      svc_cnt   <= 4'h0;
      in_svc    <= 1'b0;
      vec_ack   <= 1'b0;
      reti_done <= 1'b0;
    end else begin
      vec_ack   <= 1'b0;
      reti_done <= 1'b0;
      if (vec_req && !vec_ack && !in_svc) begin
        wait_cnt <= wait_cnt + 4'h1;
        if (wait_cnt == ack_wait) begin
          vec_ack  <= 1'b1;
          wait_cnt <= 4'h0;
          svc_cnt  <= 4'h0;
          in_svc   <= (svc_len != 4'h0);
        end
      end
      if (in_svc) begin
        svc_cnt <= svc_cnt + 4'h1;
        if (svc_cnt == svc_len) begin
          reti_done <= 1'b1;
          in_svc    <= 1'b0;
        end
      end
    end
  end
endmodule : isfl_core_model

// ---- bench/tb.sv ----
`timescale 1ns/1ps
module tb;
  logic                    ref_clk = 1'b0;
  logic                    reset_n = 1'b0;
  isfl_pkg::isfl_axi_req_s req     = '0;
  isfl_pkg::isfl_axi_rsp_s rsp;
  logic [3:0]              pin     = 4'h0;
  logic [3:0]              pin_in  = 4'hf;
  logic [3:0]              pu;
  logic [1:0]              cmp     = 2'b00;
  logic                    conv    = 1'b0;
  logic [6:0]              hit     = 7'h00;
  logic                    stk     = 1'b0;
  logic                    ack;
  logic                    reti;
  logic                    vreq;
  logic [7:0]              vaddr;
  logic                    wake;
  logic [3:0]              ack_wait = 4'h0;
  logic [3:0]              svc_len  = 4'h0;
  logic [1:0]              br;
  logic [7:0]              last_vec = 8'h00;
  int                      n_vec = 0;
  int                      miscompares = 0;
  int                      n_compared = 0;

  always #4 ref_clk = ~ref_clk;

  isfl_core dut (.ref_clk(ref_clk), .reset_n(reset_n), .axi_req(req), .axi_rsp(rsp), .ext_irq_pin(pin),
    .port_is_input(pin_in), .pull_up_on(pu), .cmp_out(cmp), .conv_end(conv), .std_timer_p_hit(hit[0]),
    .std_timer_a_hit(hit[1]), .per_timer_p_hit(hit[2]), .per_timer_a_hit(hit[3]), .low_volt_detected(hit[4]),
    .nvm_cycle_end(hit[5]), .sif_request(hit[6]), .stack_full(stk), .vec_ack(ack), .reti_done(reti),
    .vec_req(vreq), .vec_addr(vaddr), .wake_req(wake));
  isfl_core_model u_core (.ref_clk(ref_clk), .reset_n(reset_n), .vec_req(vreq), .ack_wait(ack_wait),
    .svc_len(svc_len), .vec_ack(ack), .reti_done(reti));

  always @(posedge ref_clk) begin
    if (vreq === 1'b1 && ack === 1'b1) begin
      last_vec <= vaddr;
      n_vec    <= n_vec + 1;
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    req.awvalid <= 1'b1;
    req.awaddr  <= a;
    req.wvalid  <= 1'b1;
    req.wdata   <= d;
    req.wstrb   <= 4'hf;
    req.bready  <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
    end while (rsp.bvalid !== 1'b1);
    br = rsp.bresp;
    req.bready <= 1'b0;
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] exp_r = 2'b00);
    @(posedge ref_clk);
    req.arvalid <= 1'b1;
    req.araddr  <= a;
    req.rready  <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (rsp.arready) req.arvalid <= 1'b0;
    end while (rsp.rvalid !== 1'b1);
    check(rsp.rdata, exp);
    check({30'h0, rsp.rresp}, {30'h0, exp_r});
    req.rready <= 1'b0;
  endtask : rdc

  task automatic wait_vec(input int n0, input logic [7:0] exp);
    while (n_vec == n0) @(posedge ref_clk);
    check({24'h0, last_vec}, {24'h0, exp});
  endtask : wait_vec

  task automatic t_regs();
    for (int a = 0; a < 'h18; a += 4) rdc(a[7:0], 32'h0);
    rdc(8'h18, 32'h0, isfl_pkg::RESP_SLVERR);
    wr(8'h18, 32'h1);
    check({30'h0, br}, {30'h0, isfl_pkg::RESP_SLVERR});
    wr(isfl_pkg::STAT_OFS, 32'h1ff);
    check({30'h0, br}, {30'h0, isfl_pkg::RESP_OKAY});
    rdc(isfl_pkg::STAT_OFS, 32'h0);
  endtask : t_regs

  task automatic t_edges();
    wr(isfl_pkg::CTRL_OFS, 32'h2);
    for (int m = 0; m < 4; m++) begin
      wr(isfl_pkg::EDGE_OFS, 32'h100 | m);
      pin[0] <= 1'b1;
      repeat (6) @(posedge ref_clk);
      rdc(isfl_pkg::FLAG_OFS, {31'h0, m[0]});
      wr(isfl_pkg::FLAG_OFS, 32'h1);
      pin[0] <= 1'b0;
      repeat (6) @(posedge ref_clk);
      rdc(isfl_pkg::FLAG_OFS, {31'h0, m[1]});
      wr(isfl_pkg::FLAG_OFS, 32'h1);
    end
    wr(isfl_pkg::EDGE_OFS, 32'hf003);
    pin[0] <= 1'b1;
    repeat (6) @(posedge ref_clk);
    rdc(isfl_pkg::FLAG_OFS, 32'h0);
    check({28'h0, pu}, 32'hf);
    pin_in[0] <= 1'b0;
    wr(isfl_pkg::EDGE_OFS, 32'h103);
    pin[0] <= 1'b0;
    repeat (6) @(posedge ref_clk);
    rdc(isfl_pkg::FLAG_OFS, 32'h0);
    pin_in[0] <= 1'b1;
  endtask : t_edges

  task automatic t_vector();
    int n0;
    stk <= 1'b1;
    wr(isfl_pkg::EDGE_OFS, 32'h101);
    wr(isfl_pkg::CTRL_OFS, 32'h83);
    conv   <= 1'b1;
    pin[0] <= 1'b1;
    @(posedge ref_clk);
    conv <= 1'b0;
    repeat (8) @(posedge ref_clk);
    check({31'h0, vreq}, 32'h0);
    rdc(isfl_pkg::FLAG_OFS, 32'h41);
    n0 = n_vec;
    stk <= 1'b0;
    wait_vec(n0, 8'h04);
    rdc(isfl_pkg::CTRL_OFS, 32'h82);
    rdc(isfl_pkg::FLAG_OFS, 32'h40);
    ack_wait <= 4'h4;
    n0 = n_vec;
    wr(isfl_pkg::CTRL_OFS, 32'h83);
    wait_vec(n0, 8'h1c);
    rdc(isfl_pkg::FLAG_OFS, 32'h0);
    rdc(isfl_pkg::CTRL_OFS, 32'h82);
  endtask : t_vector

  task automatic t_cmp();
    int n0;
    cmp <= 2'b01;
    repeat (6) @(posedge ref_clk);
    check({31'h0, wake}, 32'h1);
    rdc(isfl_pkg::FLAG_OFS, 32'h4);
    wr(isfl_pkg::FLAG_OFS, 32'h4);
    cmp <= 2'b10;
    repeat (6) @(posedge ref_clk);
    rdc(isfl_pkg::FLAG_OFS, 32'hc);
    wr(isfl_pkg::FLAG_OFS, 32'hc);
    n0 = n_vec;
    wr(isfl_pkg::CTRL_OFS, 32'h9);
    cmp <= 2'b11;
    wait_vec(n0, 8'h0c);
    rdc(isfl_pkg::FLAG_OFS, 32'h0);
    rdc(isfl_pkg::CTRL_OFS, 32'h8);
  endtask : t_cmp

  task automatic t_group();
    int n0;
    wr(isfl_pkg::SREN_OFS, 32'h7f);
    for (int i = 0; i < 7; i++) begin
      hit <= 7'h1 << i;
      @(posedge ref_clk);
      hit <= 7'h0;
      repeat (3) @(posedge ref_clk);
      rdc(isfl_pkg::SRFL_OFS, 32'h1 << i);
      rdc(isfl_pkg::FLAG_OFS, (i < 4) ? 32'h10 : (i < 6) ? 32'h20 : 32'h80);
      wr(isfl_pkg::SRFL_OFS, 32'h1 << i);
      wr(isfl_pkg::FLAG_OFS, 32'h3ff);
    end
    svc_len <= 4'h3;
    hit <= 7'h1;
    @(posedge ref_clk);
    hit <= 7'h0;
    n0 = n_vec;
    wr(isfl_pkg::CTRL_OFS, 32'h1);
    repeat (6) @(posedge ref_clk);
    check(n_vec, n0);
    wr(isfl_pkg::CTRL_OFS, 32'h21);
    wait_vec(n0, 8'h14);
    rdc(isfl_pkg::SRFL_OFS, 32'h1);
    rdc(isfl_pkg::FLAG_OFS, 32'h0);
    rdc(isfl_pkg::CTRL_OFS, 32'h21);
    wr(isfl_pkg::SRFL_OFS, 32'h1);
    rdc(isfl_pkg::SRFL_OFS, 32'h0);
  endtask : t_group

  task automatic stop_test();
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : stop_test

  initial begin
    repeat (20000) @(posedge ref_clk);
    miscompares++;
    stop_test();
  end

  initial begin
    repeat (8) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    t_regs();
    t_edges();
    t_vector();
    t_cmp();
    t_group();
    stop_test();
  end
endmodule : tb
